//--- logic/spi_port_pkg.sv
// Overview of operation
// - Eight-bit words shift out and in, MSb first
// - Full byte goes to buffer unless slave overflow, sets flags
// - Buffer write loads buffer and shift register
// - Write during transfer dropped, sets collision flag
// - Reading the buffer clears buffer-full
// - Slave byte into full buffer sets overflow
// - Master mode never sets overflow
// - Sample phase picks middle or end sampling in master mode
// - Clock edge bit picks output change edge
// - Clock polarity sets serial clock idle level
// - Port enable hands pins to the port
// - Mode field picks master rate or slave
// - Master transfer starts on buffer write
// - Master receives with data output disabled
// - First bit valid before first clock edge
// - Drive on one edge, latch on other; master end sampling latches on the next drive edge
// - Slave shifts on external clock, flags last
// - Slave works asleep, byte wakes device
// - Stop bit cleared while port disabled
// - Slave select high floats data out in slave mode with select (mode 4)
// - Bit counter cleared by select or disable
// - Reset disables port, aborts transfer
`default_nettype none
package spi_port_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_CONTROL = 8'h04;
  localparam logic [7:0] ADDR_BUFFER  = 8'h08;
  localparam logic [7:0] ADDR_PINCTL  = 8'h0C;
  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int         ST_SAMPLE_PHASE = 7;
  localparam int         ST_CLOCK_EDGE   = 6;
  localparam int         ST_STOP         = 4;
  localparam int         ST_BUFFER_FULL  = 0;
  localparam int         CT_WRITE_COLLISION         = 7;
  localparam int         CT_OVERFLOW     = 6;
  localparam int         CT_ENABLE       = 5;
  localparam int         CT_POLARITY     = 4;
  localparam int         PC_SDO_DISABLE  = 0;
  localparam logic [7:0] STATUS_RESET    = 8'h00;
  localparam logic [7:0] CONTROL_RESET   = 8'h00;
  // ----------------------------------------
  // Mode field codes
  // ----------------------------------------
  localparam logic [3:0] MODE_MASTER_DIV4  = 4'h0;
  localparam logic [3:0] MODE_MASTER_DIV16 = 4'h1;
  localparam logic [3:0] MODE_MASTER_DIV64 = 4'h2;
  localparam logic [3:0] MODE_MASTER_TIMER = 4'h3;
  localparam logic [3:0] MODE_SLAVE_SS     = 4'h4;
  localparam logic [3:0] MODE_SLAVE_NOSS   = 4'h5;
  // ----------------------------------------
  // Timing: system clocks per serial half period, half periods and bits per byte
  // ----------------------------------------
  localparam logic [4:0] HALF_DIV4   = 5'h02;
  localparam logic [4:0] HALF_DIV16  = 5'h08;
  localparam logic [4:0] HALF_DIV64  = 5'h10 + 5'h10 - 5'h00;
  localparam logic [4:0] HALF_STEPS  = 5'h10;
  localparam logic [3:0] BYTE_BITS   = 4'h8;
endpackage : spi_port_pkg
`default_nettype wire

//--- logic/spi_port.sv
`timescale 1ns/1ps
`default_nettype none
module spi_port (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer_match,
  input  wire logic        sleep_mode,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_data_in,
  output logic             serial_data_out,
  output logic             serial_data_out_oe,
  input  wire logic        slave_select_pin_n,
  output logic             port_interrupt_flag,
  output logic             wake_request
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic       sample_phase;
  logic       clock_edge;
  logic       buffer_full;
  logic       write_collision;
  logic       receive_overflow;
  logic       port_enable;
  logic       clock_polarity;
  logic [3:0] port_mode_field;
  logic       sdo_disable;
  logic [7:0] data_buffer;
  logic [7:0] shift_register;
  logic       sdo_bit;
  logic [3:0] bit_count;
  logic       master_busy;
  logic [4:0] half_step;
  logic [4:0] div_count;
  logic       sck_level;
  logic       sck_s1;
  logic       sck_s2;
  logic       sck_s3;
  logic       sdi_s1;
  logic       sdi_s2;
  logic       ss_s1;
  logic       ss_s2;

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic       is_master;
  logic       is_slave;
  logic       ss_gated;
  logic       access;
  logic       wr_status;
  logic       wr_control;
  logic       wr_buffer;
  logic       wr_pinctl;
  logic       rd_buffer;
  logic       mapped;
  logic       in_transfer;
  logic       collide;
  logic       load_ok;
  logic       tick;
  logic       m_edge;
  logic       m_shift;
  logic       m_sample;
  logic       s_rise;
  logic       s_fall;
  logic       s_live;
  logic       s_active_edge;
  logic       s_shift;
  logic       s_sample;
  logic       do_shift;
  logic       do_sample;
  logic       byte_done;
  logic [4:0] half_len;
  logic [7:0] next_shift;

  assign is_master = port_enable && (port_mode_field <= spi_port_pkg::MODE_MASTER_TIMER);
  assign is_slave  = port_enable && (port_mode_field == spi_port_pkg::MODE_SLAVE_SS ||
                                     port_mode_field == spi_port_pkg::MODE_SLAVE_NOSS);
  assign ss_gated  = (port_mode_field == spi_port_pkg::MODE_SLAVE_SS) && ss_s2;

  assign access     = psel && penable && pready;
  assign mapped     = (paddr == spi_port_pkg::ADDR_STATUS) || (paddr == spi_port_pkg::ADDR_CONTROL) ||
                      (paddr == spi_port_pkg::ADDR_BUFFER) || (paddr == spi_port_pkg::ADDR_PINCTL);
  assign wr_status  = access && pwrite && (paddr == spi_port_pkg::ADDR_STATUS);
  assign wr_control = access && pwrite && (paddr == spi_port_pkg::ADDR_CONTROL);
  assign wr_buffer  = access && pwrite && (paddr == spi_port_pkg::ADDR_BUFFER);
  assign wr_pinctl  = access && pwrite && (paddr == spi_port_pkg::ADDR_PINCTL);
  assign rd_buffer  = access && !pwrite && (paddr == spi_port_pkg::ADDR_BUFFER);

  assign in_transfer = master_busy || (is_slave && bit_count != 4'h0);
  assign collide     = wr_buffer && in_transfer;
  assign load_ok     = wr_buffer && !in_transfer;

  // Master bit clock source
  always_comb begin
    unique case (port_mode_field)
      spi_port_pkg::MODE_MASTER_DIV16: half_len = spi_port_pkg::HALF_DIV16;
      spi_port_pkg::MODE_MASTER_DIV64: half_len = spi_port_pkg::HALF_DIV64;
      default:                         half_len = spi_port_pkg::HALF_DIV4;
    endcase
  end
  assign tick = master_busy && ((port_mode_field == spi_port_pkg::MODE_MASTER_TIMER) ? timer_match
                                : (div_count == half_len - 5'h01));

  // Tick t < 16 is a clock edge; even t leaves idle, odd t returns to idle
  // Limitation: middle sampling at the fastest rate is too early for the input synchroniser
  assign m_edge  = tick && (half_step < spi_port_pkg::HALF_STEPS);
  assign m_shift = m_edge && (half_step[0] == clock_edge);
  always_comb begin
    if (sample_phase) begin
      m_sample = clock_edge ? (m_edge && half_step[0])
                            : (tick && !half_step[0] && half_step != 5'h00);
    end else begin
      m_sample = m_edge && (half_step[0] != clock_edge);
    end
  end

  // Slave edges from the synchronised pin
  assign s_rise        = sck_s2 && !sck_s3;
  assign s_fall        = !sck_s2 && sck_s3;
  assign s_live        = is_slave && !ss_gated;
  assign s_active_edge = clock_polarity ? s_fall : s_rise;
  assign s_shift       = s_live && (clock_edge ? !s_active_edge && (s_rise || s_fall) : s_active_edge);
  assign s_sample      = s_live && (clock_edge ? s_active_edge : (s_rise || s_fall) && !s_active_edge);

  assign do_shift  = is_master ? m_shift : s_shift;
  assign do_sample = is_master ? m_sample : s_sample;
  assign next_shift = {shift_register[6:0], sdi_s2};
  assign byte_done  = do_sample && (bit_count == spi_port_pkg::BYTE_BITS - 4'h1);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
      ss_s1  <= 1'b1;
      ss_s2  <= 1'b1;
    end else begin
      sck_s1 <= serial_clock_pin_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sdi_s1 <= serial_data_in;
      sdi_s2 <= sdi_s1;
      ss_s1  <= slave_select_pin_n;
      ss_s2  <= ss_s1;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_phase    <= spi_port_pkg::STATUS_RESET[spi_port_pkg::ST_SAMPLE_PHASE];
      clock_edge      <= spi_port_pkg::STATUS_RESET[spi_port_pkg::ST_CLOCK_EDGE];
      port_enable     <= spi_port_pkg::CONTROL_RESET[spi_port_pkg::CT_ENABLE];
      clock_polarity  <= spi_port_pkg::CONTROL_RESET[spi_port_pkg::CT_POLARITY];
      port_mode_field <= spi_port_pkg::CONTROL_RESET[3:0];
      sdo_disable     <= 1'b0;
    end else begin
      if (wr_status) begin
        sample_phase <= pwdata[spi_port_pkg::ST_SAMPLE_PHASE];
        clock_edge   <= pwdata[spi_port_pkg::ST_CLOCK_EDGE];
      end
      if (wr_control) begin
        port_enable     <= pwdata[spi_port_pkg::CT_ENABLE];
        clock_polarity  <= pwdata[spi_port_pkg::CT_POLARITY];
        port_mode_field <= pwdata[3:0];
      end
      if (wr_pinctl) begin
        sdo_disable <= pwdata[spi_port_pkg::PC_SDO_DISABLE];
      end
    end
  end

  // ----------------------------------------
  // Sticky flags; hardware set wins over clear
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      write_collision  <= 1'b0;
      receive_overflow <= 1'b0;
      buffer_full      <= 1'b0;
    end else begin
      if (collide) begin
        write_collision <= 1'b1;
      end else if (wr_control) begin
        write_collision <= pwdata[spi_port_pkg::CT_WRITE_COLLISION];
      end
      if (byte_done && is_slave && buffer_full) begin
        receive_overflow <= 1'b1;
      end else if (wr_control) begin
        receive_overflow <= pwdata[spi_port_pkg::CT_OVERFLOW];
      end
      if (byte_done) begin
        buffer_full <= 1'b1;
      end else if (rd_buffer) begin
        buffer_full <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Buffer and shift register
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_buffer    <= 8'h00;
      shift_register <= 8'h00;
      sdo_bit        <= 1'b0;
    end else begin
      if (load_ok) begin
        data_buffer    <= pwdata[7:0];
        shift_register <= pwdata[7:0];
        sdo_bit        <= pwdata[7];
      end else begin
        if (byte_done && !(is_slave && buffer_full)) begin
          data_buffer <= next_shift;
        end
        if (do_sample) begin
          shift_register <= next_shift;
        end
        // Sample and shift on one edge: next bit is already one place up
        if (do_shift) begin
          sdo_bit <= do_sample ? shift_register[6] : shift_register[7];
        end
      end
    end
  end

  // ----------------------------------------
  // Bit counter
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bit_count <= 4'h0;
    end else if (!port_enable || (is_slave && ss_gated)) begin
      bit_count <= 4'h0;
    end else if (byte_done) begin
      bit_count <= 4'h0;
    end else if (do_sample) begin
      bit_count <= bit_count + 4'h1;
    end
  end

  // ----------------------------------------
  // Master clock generator
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      master_busy <= 1'b0;
      half_step   <= 5'h00;
      div_count   <= 5'h00;
      sck_level   <= 1'b0;
    end else if (!is_master) begin
      master_busy <= 1'b0;
      half_step   <= 5'h00;
      div_count   <= 5'h00;
      sck_level   <= clock_polarity;
    end else if (load_ok) begin
      master_busy <= 1'b1;
      half_step   <= 5'h00;
      div_count   <= 5'h00;
      sck_level   <= clock_polarity;
    end else if (master_busy) begin
      div_count <= tick ? 5'h00 : div_count + 5'h01;
      if (tick) begin
        half_step <= half_step + 5'h01;
        if (half_step == spi_port_pkg::HALF_STEPS) begin
          master_busy <= 1'b0;
        end
      end
      if (m_edge) begin
        sck_level <= !sck_level;
      end
    end else begin
      sck_level <= clock_polarity;
    end
  end

  // ----------------------------------------
  // Pin drivers and events
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serial_clock_pin_out <= 1'b0;
      serial_clock_pin_oe  <= 1'b0;
      serial_data_out      <= 1'b0;
      serial_data_out_oe   <= 1'b0;
      port_interrupt_flag  <= 1'b0;
      wake_request         <= 1'b0;
    end else begin
      serial_clock_pin_out <= master_busy ? sck_level : clock_polarity;
      serial_clock_pin_oe  <= is_master;
      serial_data_out      <= sdo_bit;
      serial_data_out_oe   <= (is_master || (is_slave && !ss_gated)) && !sdo_disable;
      port_interrupt_flag  <= byte_done;
      // Slave logic runs on the system clock, which stays up in sleep
      wake_request         <= byte_done && is_slave && sleep_mode;
    end
  end

  // ----------------------------------------
  // APB slave, one wait state
  // ----------------------------------------
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && penable && !pready && !pwrite) begin
        unique case (paddr)
          // Stop bit never sets in this mode, so it reads clear while disabled
          spi_port_pkg::ADDR_STATUS:  prdata[7:0] <= {sample_phase, clock_edge, 5'h00, buffer_full};
          spi_port_pkg::ADDR_CONTROL: prdata[7:0] <= {write_collision, receive_overflow, port_enable,
                                                      clock_polarity, port_mode_field};
          spi_port_pkg::ADDR_BUFFER:  prdata[7:0] <= data_buffer;
          spi_port_pkg::ADDR_PINCTL:  prdata[7:0] <= {7'h00, sdo_disable};
          default:                    prdata      <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : spi_port
`default_nettype wire

//--- testbench/spi_port_checker.sv
`timescale 1ns/1ps
`default_nettype none
module spi_port_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        timer_match,
  input wire logic        serial_clock_pin_out,
  input wire logic        serial_clock_pin_oe,
  input wire logic        serial_data_out_oe,
  input wire logic        slave_select_pin_n,
  input wire logic        port_interrupt_flag,
  input wire logic        wake_request
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Control shadow, taken from bus writes
  // ----------------------------------------
  logic [7:0] ctl;
  logic       on;
  logic       mapped;
  assign on     = ctl[5];
  assign mapped = paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl <= 8'h00;
    end else if (psel && penable && pready && pwrite && paddr == spi_port_pkg::ADDR_CONTROL) begin
      ctl <= pwdata[7:0];
    end
  end
  access_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("access phase not answered");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  error_map_a: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match map");
  flag_pulse_a: assert property (port_interrupt_flag |=> !port_interrupt_flag)
    else $error("byte flag held too long");
  wake_cause_a: assert property (wake_request |-> port_interrupt_flag)
    else $error("wake without completed byte");
  pins_off_a: assert property (!on [*2] |-> !serial_clock_pin_oe && !serial_data_out_oe)
    else $error("pins driven while disabled");
  clock_drive_a: assert property ((on && $stable(ctl)) [*2] |-> serial_clock_pin_oe == (ctl[3:0] <= 4'h3))
    else $error("clock drive does not match mode");
  select_float_a: assert property ((on && ctl[3:0] == 4'h4 && slave_select_pin_n) [*5] |-> !serial_data_out_oe)
    else $error("data out driven while deselected");
  fast_half_a: assert property (on && ctl[3:0] == 4'h0 && serial_clock_pin_oe && $changed(serial_clock_pin_out)
    |=> $stable(serial_clock_pin_out))
    else $error("fast clock half period too short");
  mid_half_a: assert property (on && ctl[3:0] == 4'h1 && serial_clock_pin_oe && $changed(serial_clock_pin_out)
    |=> $stable(serial_clock_pin_out) [*7])
    else $error("medium clock half period too short");
  timer_step_a: assert property (on && ctl[3:0] == 4'h3 && serial_clock_pin_oe && $changed(serial_clock_pin_out)
    |-> $past(timer_match) || $past(timer_match, 2))
    else $error("timer clock moved without match");
  cover property (wake_request);
  cover property (pslverr);
  cover property (port_interrupt_flag && ctl[3:0] == 4'h3);
endmodule : spi_port_checker
`default_nettype wire

//--- testbench/spi_peer_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_peer_model (
  input  wire logic       sclk,
  input  wire logic       cpol,
  input  wire logic       cke,
  input  wire logic       active,
  input  wire logic       mosi,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic      [7:0] rx_byte
);
  logic [7:0] shift;
  // ----------------------------------------
  // Peripheral shift logic
  // ----------------------------------------
  // Released line flips, so a stale bit never passes
  always @(active) begin
    miso = (miso === 1'b1) ? 1'b0 : 1'b1;
    if (active) begin
      shift = tx_byte;
      if (cke) begin
        miso  = shift[7];
        shift = shift << 1;
      end
    end
  end
  always @(sclk) begin
    if (active && ((sclk != cpol) ^ cke)) begin
      miso  = shift[7];
      shift = shift << 1;
    end else if (active) begin
      rx_byte = {rx_byte[6:0], mosi};
    end
  end
endmodule : spi_peer_model
`default_nettype wire

//--- testbench/spi_master_slave_port_test.sv
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_port_test;
  logic        sys_clk, rst, psel, penable, pwrite, timer_match, sleep_mode;
  logic        sck_in, sdi_tb, ss_n, slave_on, peer_on, cpol, cke, err;
  logic        pready, pslverr, sck_out, sck_oe, sdo, sdo_oe, irq, wake, peer_miso;
  logic [7:0]  paddr, peer_tx, peer_rx, rd_val;
  logic [31:0] pwdata, prdata;
  logic [1:0]  tcnt;
  int          mismatches, samples_checked;
  wire logic   sdi = slave_on ? sdi_tb : peer_miso;
  spi_port i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_match(timer_match), .sleep_mode(sleep_mode), .serial_clock_pin_in(sck_in),
    .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe), .serial_data_in(sdi),
    .serial_data_out(sdo), .serial_data_out_oe(sdo_oe), .slave_select_pin_n(ss_n),
    .port_interrupt_flag(irq), .wake_request(wake));
  spi_peer_model i_peer (.sclk(sck_out), .cpol(cpol), .cke(cke), .active(peer_on), .mosi(sdo),
    .tx_byte(peer_tx), .miso(peer_miso), .rx_byte(peer_rx));
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    tcnt        <= tcnt + 2'h1;
    timer_match <= &tcnt;
  end
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic close_out();
    $display("mismatches=%0d samples_checked=%0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic hung();
    mismatches++;
    close_out();
  endtask : hung
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    @(posedge sys_clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) hung();
    rd_val  = prdata[7:0];
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 8'h00);
    chk(rd_val, e);
  endtask : rd
  task automatic wait_flag();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (irq !== 1'b1 && n < 3000);
    if (n >= 3000) hung();
  endtask : wait_flag
  task automatic send(input logic [7:0] b, input int nb, output logic [7:0] got);
    for (int i = 7; i > 7 - nb; i--) begin
      repeat (8) @(posedge sys_clk);
      sck_in <= 1'b1;
      sdi_tb <= b[i];
      repeat (8) @(posedge sys_clk);
      got[i] = sdo;
      sck_in <= 1'b0;
    end
  endtask : send
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs();
    rd(8'h00, 8'h00);
    rd(8'h04, 8'h00);
    apb(1'b1, 8'h00, 8'hFF);
    rd(8'h00, 8'hC0);
    apb(1'b1, 8'h00, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    chk({7'h00, err}, 8'h01);
    chk(rd_val, 8'h00);
  endtask : t_regs
  task automatic t_master(input logic [3:0] m, input logic p, input logic [7:0] st, input logic [7:0] tx,
                          input logic [7:0] rx, input logic dis);
    cpol    <= p;
    cke     <= st[6];
    peer_tx <= rx;
    apb(1'b1, 8'h04, {3'h0, p, m});
    apb(1'b1, 8'h00, st);
    apb(1'b1, 8'h0C, {7'h00, dis});
    apb(1'b1, 8'h04, {3'h1, p, m});
    peer_on <= 1'b1;
    rd(8'h00, st);
    chk({7'h00, sck_out}, {7'h00, p});
    apb(1'b1, 8'h08, tx);
    apb(1'b1, 8'h08, 8'h00);
    chk({7'h00, sdo_oe}, {7'h00, !dis});
    wait_flag();
    rd(8'h04, {3'h5, p, m});
    rd(8'h00, st | 8'h01);
    rd(8'h08, rx);
    rd(8'h00, st);
    if (!dis) chk(peer_rx, tx);
    peer_on <= 1'b0;
    apb(1'b1, 8'h04, {3'h0, p, m});
  endtask : t_master
  task automatic t_slave();
    logic [7:0] got;
    slave_on   <= 1'b1;
    sleep_mode <= 1'b1;
    ss_n       <= 1'b0;
    apb(1'b1, 8'h04, 8'h04);
    apb(1'b1, 8'h24, 8'h24);
    apb(1'b1, 8'h04, 8'h24);
    apb(1'b1, 8'h08, 8'h4B);
    send(8'hB4, 8, got);
    wait_flag();
    chk({7'h00, wake}, 8'h01);
    chk(got, 8'h4B);
    send(8'h2D, 8, got);
    wait_flag();
    rd(8'h04, 8'h64);
    rd(8'h08, 8'hB4);
    rd(8'h00, 8'h00);
    send(8'hFF, 3, got);
    ss_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
    chk({7'h00, sdo_oe}, 8'h00);
    ss_n <= 1'b0;
    send(8'h77, 8, got);
    wait_flag();
    rd(8'h08, 8'h77);
    apb(1'b1, 8'h04, 8'h00);
    slave_on <= 1'b0;
  endtask : t_slave
  task automatic t_reset();
    apb(1'b1, 8'h04, 8'h22);
    apb(1'b1, 8'h08, 8'hF0);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    chk({7'h00, sck_oe}, 8'h00);
    rd(8'h04, 8'h00);
  endtask : t_reset
  initial begin
    {sys_clk, psel, penable, pwrite, timer_match, sleep_mode, sck_in, sdi_tb} = 8'h00;
    {slave_on, peer_on, cpol, cke, tcnt, paddr, pwdata, peer_tx} = 54'h0;
    rst  = 1'b1;
    ss_n = 1'b1;
    mismatches      = 0;
    samples_checked = 0;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_master(4'h0, 1'b0, 8'h80, 8'hA5, 8'h3C, 1'b0);
    t_master(4'h1, 1'b1, 8'h40, 8'h5A, 8'hC3, 1'b0);
    t_master(4'h2, 1'b0, 8'hC0, 8'h81, 8'h7E, 1'b1);
    t_master(4'h3, 1'b1, 8'h00, 8'h96, 8'h69, 1'b0);
    t_slave();
    t_reset();
    close_out();
  end
endmodule : spi_master_slave_port_test
bind spi_port spi_port_checker u_chk (.*);
`default_nettype wire
